// >>> core/afp_pkg.sv
`default_nettype none
package afp_pkg;
	// register map, byte addresses
	localparam int AFP_ADR_W = 8;
	localparam logic [7:0] AFP_CTRL_OFS = 8'hec;
	localparam logic [7:0] AFP_HDR_OFS = 8'he8;

	// bit positions in the path control register
	localparam int AFP_B_IRX_ON = 0;
	localparam int AFP_B_ITX_ON = 1;
	localparam int AFP_B_ARX_ON = 2;
	localparam int AFP_B_ATX_ON = 3;
	localparam int AFP_B_ISNP = 15;
	localparam int AFP_B_IHADD = 16;
	localparam int AFP_B_IHRM = 19;
	localparam int AFP_B_IRDST = 20;
	localparam int AFP_B_ITSRC = 21;
	localparam int AFP_B_IRCLR = 22;
	localparam int AFP_B_ITCLR = 23;
	localparam int AFP_B_AHADD = 24;

	// values after reset and masks
	localparam logic [31:0] AFP_CTRL_RST = 32'h00000000;
	localparam logic [31:0] AFP_HDR_RST = 32'h00000000;
	localparam logic [31:0] AFP_CTRL_WMASK = 32'h0139800f;

	// one quadlet on a stream
	typedef struct packed {
		logic vld;
		logic sop;
		logic [31:0] data;
	} afp_q_s;

	// decoded modes that steer the fifo paths
	typedef struct packed {
		logic iso_rx_fifo_on;
		logic iso_tx_fifo_on;
		logic async_rx_fifo_on;
		logic async_tx_fifo_on;
		logic iso_capture_all;
		logic iso_auto_header_add;
		logic iso_header_remove;
		logic iso_rx_dest_select;
		logic iso_tx_source_select;
		logic async_auto_header_add;
	} afp_mode_s;
endpackage
`default_nettype wire

// >>> core/afp_wb_slave.sv
`default_nettype none
module afp_wb_slave (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic cyc, // wishbone cycle
	input wire logic stb, // wishbone strobe
	output logic ack, // wishbone acknowledge
	output logic start, // request seen, ack not yet given
	output logic take // ack edge, write commits here
);
	// one wait state, ack drops in the cycle after it was given
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= cyc & stb & ~ack;
		end
	end

	assign start = cyc & stb & ~ack;
	assign take = cyc & stb & ack;

	c_bus_answer: cover property (@(posedge clk) disable iff (!rst_n) start ##1 take);
endmodule
`default_nettype wire

// >>> core/afp_hdr_strip.sv
`default_nettype none
module afp_hdr_strip (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic clr, // flush or soft reset
	input wire logic strip_on, // remove header quadlet
	input wire afp_pkg::afp_q_s in_q, // accepted receive stream
	output afp_pkg::afp_q_s out_q, // stream toward receive fifo
	output logic [31:0] hdr // last removed header
);
	logic take_hdr;
	logic pend_sop;

	assign take_hdr = in_q.vld & in_q.sop & strip_on;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= '0;
		end else if (clr) begin
			out_q <= '0;
		end else begin
			out_q.vld <= in_q.vld & ~take_hdr;
			out_q.sop <= in_q.vld & ~take_hdr & (in_q.sop | pend_sop);
			out_q.data <= in_q.data;
		end
	end

	// first payload quadlet inherits the start mark
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_sop <= 1'b0;
		end else if (clr) begin
			pend_sop <= 1'b0;
		end else if (take_hdr) begin
			pend_sop <= 1'b1;
		end else if (in_q.vld) begin
			pend_sop <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hdr <= afp_pkg::AFP_HDR_RST;
		end else if (clr) begin
			hdr <= afp_pkg::AFP_HDR_RST;
		end else if (take_hdr) begin
			hdr <= in_q.data;
		end
	end
endmodule
`default_nettype wire

// >>> core/afp_ctrl.sv
// Functional notes
// - all control bits clear on power-up and soft reset
// - isochronous receive fifo accepts data only while its enable is set
// - isochronous transmit fifo may send only while its enable is set
// - asynchronous receive fifo accepts data only while its enable is set
// - asynchronous transmit fifo may send only while its enable is set
// - serial-bus reset clears asynchronous transmit enable, overriding software
// - capture-all mode stores every isochronous packet, any channel
// - header-add mode: payload only loaded, device builds isochronous headers
// - header-remove mode delivers payload only, header kept in holding register
// - destination zero: micro port reads receive fifo, bulk port gets nothing
// - destination one: bulk port gets packets, micro reads ignored
// - source zero: micro writes fill transmit fifo, bulk writes dropped
// - source one: bulk port writes fill transmit fifo, micro writes dropped
// - writing one to bit 22 flushes receive fifo, bit self clears
// - writing one to bit 23 flushes transmit fifo, bit self clears
// - async header-add mode: payload only, device builds headers
`default_nettype none
module afp_ctrl (
	input wire logic clk, // core clock, 250 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic soft_reset, // software reset pulse
	input wire logic bus_reset, // serial-bus reset pulse
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte enables
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	output afp_pkg::afp_mode_s mode, // decoded path modes
	input wire afp_pkg::afp_q_s link_iso_rx, // received isochronous quadlets
	input wire logic link_iso_chan_hit, // packet channel is ours
	output afp_pkg::afp_q_s iso_rx_fifo_wr, // write into iso receive fifo
	output logic [31:0] iso_rx_header, // holding register of removed header
	input wire afp_pkg::afp_q_s rx_fifo_head, // head of iso receive fifo
	output logic rx_fifo_pop, // pop iso receive fifo
	input wire logic micro_host_port_rd, // micro read request pulse
	output logic [31:0] micro_host_port_rd_data, // quadlet read by micro
	input wire logic bulk_app_port_rx_ready, // bulk port can take data
	output afp_pkg::afp_q_s bulk_app_port_rx, // quadlets to bulk port
	input wire afp_pkg::afp_q_s micro_host_port_wr, // micro transmit writes
	input wire afp_pkg::afp_q_s bulk_app_port_wr, // bulk port transmit writes
	output afp_pkg::afp_q_s iso_tx_fifo_wr, // write into iso transmit fifo
	output logic iso_rx_fifo_clear, // flush iso receive fifo pulse
	output logic iso_tx_fifo_clear // flush iso transmit fifo pulse
);
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [31:0] lanes;
	logic [31:0] wdat;
	logic [31:0] rd_mux;
	logic bus_start;
	logic bus_take;
	logic wr_ctrl;
	logic rx_accept;
	logic rx_clr;
	afp_pkg::afp_q_s rx_gated;
	afp_pkg::afp_q_s tx_pick;

	// word decode on byte address
	function automatic logic afp_hit(input logic [7:0] adr, input logic [7:0] ofs);
		afp_hit = (adr[7:2] == ofs[7:2]);
	endfunction

	// expand byte enables to a bit mask
	function automatic logic [31:0] afp_lanes(input logic [3:0] sel);
		afp_lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	afp_wb_slave u_bus (
		.clk(clk),
		.rst_n(rst_n),
		.cyc(wb_cyc_i),
		.stb(wb_stb_i),
		.ack(wb_ack_o),
		.start(bus_start),
		.take(bus_take)
	);

	assign lanes = afp_lanes(wb_sel_i);
	assign wdat = wb_dat_i & lanes;
	assign wr_ctrl = bus_take & wb_we_i & afp_hit(wb_adr_i, afp_pkg::AFP_CTRL_OFS);

	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = ((ctrl & ~lanes) | wdat) & afp_pkg::AFP_CTRL_WMASK;
		end
		if (bus_reset) begin
			next_ctrl[afp_pkg::AFP_B_ATX_ON] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= afp_pkg::AFP_CTRL_RST;
		end else if (soft_reset) begin
			ctrl <= afp_pkg::AFP_CTRL_RST;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	always_comb begin
		mode.iso_rx_fifo_on = ctrl[afp_pkg::AFP_B_IRX_ON];
		mode.iso_tx_fifo_on = ctrl[afp_pkg::AFP_B_ITX_ON];
		mode.async_rx_fifo_on = ctrl[afp_pkg::AFP_B_ARX_ON];
		mode.async_tx_fifo_on = ctrl[afp_pkg::AFP_B_ATX_ON];
		mode.iso_capture_all = ctrl[afp_pkg::AFP_B_ISNP];
		mode.iso_auto_header_add = ctrl[afp_pkg::AFP_B_IHADD];
		mode.iso_header_remove = ctrl[afp_pkg::AFP_B_IHRM];
		mode.iso_rx_dest_select = ctrl[afp_pkg::AFP_B_IRDST];
		mode.iso_tx_source_select = ctrl[afp_pkg::AFP_B_ITSRC];
		mode.async_auto_header_add = ctrl[afp_pkg::AFP_B_AHADD];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iso_rx_fifo_clear <= 1'b0;
		end else begin
			iso_rx_fifo_clear <= wr_ctrl & wdat[afp_pkg::AFP_B_IRCLR];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iso_tx_fifo_clear <= 1'b0;
		end else begin
			iso_tx_fifo_clear <= wr_ctrl & wdat[afp_pkg::AFP_B_ITCLR];
		end
	end

	// flush bits are write only and read zero
	always_comb begin
		rd_mux = 32'h00000000;
		if (afp_hit(wb_adr_i, afp_pkg::AFP_CTRL_OFS)) begin
			rd_mux = ctrl & afp_pkg::AFP_CTRL_WMASK;
		end else if (afp_hit(wb_adr_i, afp_pkg::AFP_HDR_OFS)) begin
			rd_mux = iso_rx_header;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (bus_start) begin
			wb_dat_o <= rd_mux;
		end
	end

	assign rx_accept = link_iso_rx.vld & mode.iso_rx_fifo_on &
		(link_iso_chan_hit | mode.iso_capture_all);

	always_comb begin
		rx_gated = link_iso_rx;
		rx_gated.vld = rx_accept;
	end

	assign rx_clr = soft_reset | iso_rx_fifo_clear;

	afp_hdr_strip u_strip (
		.clk(clk),
		.rst_n(rst_n),
		.clr(rx_clr),
		.strip_on(mode.iso_header_remove),
		.in_q(rx_gated),
		.out_q(iso_rx_fifo_wr),
		.hdr(iso_rx_header)
	);

	assign rx_fifo_pop = rx_fifo_head.vld & (mode.iso_rx_dest_select ?
		bulk_app_port_rx_ready : micro_host_port_rd);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			micro_host_port_rd_data <= 32'h00000000;
		end else if (soft_reset) begin
			micro_host_port_rd_data <= 32'h00000000;
		end else if (rx_fifo_pop & ~mode.iso_rx_dest_select) begin
			micro_host_port_rd_data <= rx_fifo_head.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bulk_app_port_rx <= '0;
		end else if (soft_reset) begin
			bulk_app_port_rx <= '0;
		end else begin
			bulk_app_port_rx.vld <= rx_fifo_pop & mode.iso_rx_dest_select;
			bulk_app_port_rx.sop <= rx_fifo_head.sop;
			bulk_app_port_rx.data <= rx_fifo_head.data;
		end
	end

	assign tx_pick = mode.iso_tx_source_select ? bulk_app_port_wr : micro_host_port_wr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			iso_tx_fifo_wr <= '0;
		end else if (soft_reset | iso_tx_fifo_clear) begin
			iso_tx_fifo_wr <= '0;
		end else begin
			iso_tx_fifo_wr <= tx_pick;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_soft_reset_clear: assert property (
		soft_reset |=> (ctrl == afp_pkg::AFP_CTRL_RST) && !iso_rx_fifo_wr.vld)
		else $error("soft reset left control bits set");

	a_bus_reset_atx: assert property (
		bus_reset |=> !mode.async_tx_fifo_on)
		else $error("bus reset did not clear async transmit enable");

	a_rx_gate_enable: assert property (
		iso_rx_fifo_wr.vld |-> $past(mode.iso_rx_fifo_on) && $past(link_iso_rx.vld))
		else $error("receive fifo written while disabled");

	a_capture_all: assert property (
		link_iso_rx.vld && mode.iso_rx_fifo_on && mode.iso_capture_all &&
		!(link_iso_rx.sop && mode.iso_header_remove) && !rx_clr
		|=> iso_rx_fifo_wr.vld && (iso_rx_fifo_wr.data == $past(link_iso_rx.data)))
		else $error("capture-all packet not stored");

	a_enable_stable: assert property (
		!wr_ctrl && !soft_reset && !bus_reset |=> $stable(ctrl))
		else $error("control bits changed without cause");

	a_header_strip: assert property (
		rx_accept && link_iso_rx.sop && mode.iso_header_remove && !rx_clr
		|=> !iso_rx_fifo_wr.vld && (iso_rx_header == $past(link_iso_rx.data)))
		else $error("header not removed into holding register");

	a_micro_read: assert property (
		!mode.iso_rx_dest_select && micro_host_port_rd && rx_fifo_head.vld && !soft_reset
		|-> rx_fifo_pop ##1 (micro_host_port_rd_data == $past(rx_fifo_head.data)))
		else $error("micro read not served");

	a_bulk_blocked: assert property (
		bulk_app_port_rx.vld |-> $past(mode.iso_rx_dest_select))
		else $error("bulk port received while micro selected");

	a_micro_ignored: assert property (
		mode.iso_rx_dest_select && !soft_reset |=> $stable(micro_host_port_rd_data))
		else $error("micro read taken while bulk selected");

	a_tx_micro_src: assert property (
		!mode.iso_tx_source_select && !soft_reset && !iso_tx_fifo_clear
		|=> iso_tx_fifo_wr == $past(micro_host_port_wr))
		else $error("transmit fifo not fed from micro port");

	a_tx_bulk_src: assert property (
		mode.iso_tx_source_select && !soft_reset && !iso_tx_fifo_clear
		|=> iso_tx_fifo_wr == $past(bulk_app_port_wr))
		else $error("transmit fifo not fed from bulk port");

	a_rx_flush_pulse: assert property (
		wr_ctrl && wdat[afp_pkg::AFP_B_IRCLR] |=> iso_rx_fifo_clear ##1 !iso_rx_fifo_clear)
		else $error("receive flush not a single pulse");

	a_tx_flush_pulse: assert property (
		wr_ctrl && wdat[afp_pkg::AFP_B_ITCLR] |=> iso_tx_fifo_clear ##1 !iso_tx_fifo_clear)
		else $error("transmit flush not a single pulse");

	a_reserved_zero: assert property (
		wb_ack_o && !wb_we_i && afp_hit(wb_adr_i, afp_pkg::AFP_CTRL_OFS)
		|-> (wb_dat_o & ~afp_pkg::AFP_CTRL_WMASK) == 32'h00000000)
		else $error("reserved bits read nonzero");

	a_iso_rx_write: assert property (
		wr_ctrl && wb_sel_i[0] && !soft_reset
		|=> mode.iso_rx_fifo_on == $past(wb_dat_i[afp_pkg::AFP_B_IRX_ON]))
		else $error("iso receive enable not written");

	a_iso_tx_write: assert property (
		wr_ctrl && wb_sel_i[0] && !soft_reset
		|=> mode.iso_tx_fifo_on == $past(wb_dat_i[afp_pkg::AFP_B_ITX_ON]))
		else $error("iso transmit enable not written");

	a_async_rx_write: assert property (
		wr_ctrl && wb_sel_i[0] && !soft_reset
		|=> mode.async_rx_fifo_on == $past(wb_dat_i[afp_pkg::AFP_B_ARX_ON]))
		else $error("async receive enable not written");

	a_async_tx_write: assert property (
		wr_ctrl && wb_sel_i[0] && !soft_reset && !bus_reset
		|=> mode.async_tx_fifo_on == $past(wb_dat_i[afp_pkg::AFP_B_ATX_ON]))
		else $error("async transmit enable not written");

	a_header_add_flags: assert property (
		wr_ctrl && wb_sel_i[2] && wb_sel_i[3] && !soft_reset
		|=> mode.iso_auto_header_add == $past(wb_dat_i[afp_pkg::AFP_B_IHADD]) &&
		mode.async_auto_header_add == $past(wb_dat_i[afp_pkg::AFP_B_AHADD]))
		else $error("header add flags not written");

	a_rx_flush_drop: assert property (
		iso_rx_fifo_clear |=> !iso_rx_fifo_wr.vld)
		else $error("receive fifo written during flush");

	a_tx_flush_drop: assert property (
		iso_tx_fifo_clear |=> !iso_tx_fifo_wr.vld)
		else $error("transmit fifo written during flush");

	a_flush_read_zero: assert property (
		wb_ack_o && !wb_we_i && afp_hit(wb_adr_i, afp_pkg::AFP_CTRL_OFS)
		|-> !wb_dat_o[afp_pkg::AFP_B_IRCLR] && !wb_dat_o[afp_pkg::AFP_B_ITCLR])
		else $error("flush bits read nonzero");

	a_sop_with_data: assert property (
		iso_rx_fifo_wr.sop |-> iso_rx_fifo_wr.vld)
		else $error("start mark without a written quadlet");

	a_empty_no_pop: assert property (
		!rx_fifo_head.vld |-> !rx_fifo_pop)
		else $error("pop from empty receive fifo");

	a_bulk_data: assert property (
		bulk_app_port_rx.vld |-> bulk_app_port_rx.data == $past(rx_fifo_head.data))
		else $error("bulk port data not the popped quadlet");

	c_snoop_capture: cover property (
		link_iso_rx.vld && !link_iso_chan_hit && mode.iso_capture_all ##1 iso_rx_fifo_wr.vld);

	c_strip_packet: cover property (
		rx_accept && link_iso_rx.sop && mode.iso_header_remove ##1 rx_accept);

	c_bulk_read: cover property (rx_fifo_pop && mode.iso_rx_dest_select);

	c_flush_both: cover property (iso_rx_fifo_clear && iso_tx_fifo_clear);
endmodule
`default_nettype wire

// >>> verif/tb_app_fifo_path_control.sv
`default_nettype none
module tb_app_fifo_path_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ctl_a = afp_pkg::AFP_CTRL_OFS;
	localparam logic [7:0] hdr_a = afp_pkg::AFP_HDR_OFS;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic soft_reset = 1'b0;
	logic bus_reset = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat, hdr, mrd_data, q;
	logic ack, pop, rclr, tclr;
	logic chan_hit = 1'b0;
	logic mrd = 1'b0;
	logic brdy = 1'b0;
	afp_pkg::afp_mode_s mode;
	afp_pkg::afp_q_s lrx = '0;
	afp_pkg::afp_q_s head = '0;
	afp_pkg::afp_q_s mwr = '0;
	afp_pkg::afp_q_s bwr = '0;
	afp_pkg::afp_q_s rx_wr, bulk_rx, tx_wr;
	int failures = 0;
	int tests_run = 0;

	always #2 clk = ~clk;

	afp_ctrl afp_ctrl_inst (
		.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .bus_reset(bus_reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mode(mode),
		.link_iso_rx(lrx), .link_iso_chan_hit(chan_hit), .iso_rx_fifo_wr(rx_wr),
		.iso_rx_header(hdr), .rx_fifo_head(head), .rx_fifo_pop(pop),
		.micro_host_port_rd(mrd), .micro_host_port_rd_data(mrd_data),
		.bulk_app_port_rx_ready(brdy), .bulk_app_port_rx(bulk_rx),
		.micro_host_port_wr(mwr), .bulk_app_port_wr(bwr), .iso_tx_fifo_wr(tx_wr),
		.iso_rx_fifo_clear(rclr), .iso_tx_fifo_clear(tclr)
	);

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle, waits for ack, read data lands in q
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
			input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rx(input logic s, input logic [31:0] d, input logic ev, input logic es);
		@(posedge clk);
		lrx <= '{vld: 1'b1, sop: s, data: d};
		@(posedge clk);
		lrx <= '0;
		@(negedge clk);
		chk({30'h0, rx_wr.vld, rx_wr.sop}, {30'h0, ev, es});
		if (ev) chk(rx_wr.data, d);
	endtask

	task automatic rd(input logic m, input logic b, input logic ep);
		@(posedge clk);
		mrd <= m;
		brdy <= b;
		@(negedge clk);
		chk({31'h0, pop}, {31'h0, ep});
		@(posedge clk);
		mrd <= 1'b0;
		brdy <= 1'b0;
		@(negedge clk);
	endtask

	task automatic tx(input logic [31:0] dm, input logic [31:0] db, input logic [31:0] e);
		@(posedge clk);
		mwr <= '{vld: 1'b1, sop: 1'b0, data: dm};
		bwr <= '{vld: 1'b1, sop: 1'b0, data: db};
		@(posedge clk);
		mwr <= '0;
		bwr <= '0;
		@(negedge clk);
		chk({31'h0, tx_wr.vld}, 32'h1);
		chk(tx_wr.data, e);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, ctl_a, 4'hf, 32'h0);
		chk(q, 32'h00000000);
		wb(1'b0, hdr_a, 4'hf, 32'h0);
		chk(q, 32'h00000000);
		$display("test reset values done");
		wb(1'b1, ctl_a, 4'hf, 32'hffffffff);
		@(negedge clk);
		chk({30'h0, rclr, tclr}, 32'h3);
		@(negedge clk);
		chk({30'h0, rclr, tclr}, 32'h0);
		chk({22'h0, mode}, 32'h3ff);
		wb(1'b0, ctl_a, 4'hf, 32'h0);
		chk(q, 32'h0139800f);
		wb(1'b1, ctl_a, 4'h1, 32'h0);
		wb(1'b0, ctl_a, 4'hf, 32'h0);
		chk(q, 32'h01398000);
		wb(1'b1, 8'h10, 4'hf, 32'hffffffff);
		wb(1'b0, 8'h10, 4'hf, 32'h0);
		chk(q, 32'h00000000);
		$display("test register access done");
		wb(1'b1, ctl_a, 4'hf, 32'h0000000f);
		@(posedge clk);
		bus_reset <= 1'b1;
		@(posedge clk);
		bus_reset <= 1'b0;
		@(negedge clk);
		chk({31'h0, mode.async_tx_fifo_on}, 32'h0);
		wb(1'b0, ctl_a, 4'hf, 32'h0);
		chk(q, 32'h00000007);
		bus_reset <= 1'b1;
		wb(1'b1, ctl_a, 4'hf, 32'h0000000f);
		bus_reset <= 1'b0;
		wb(1'b0, ctl_a, 4'hf, 32'h0);
		chk(q, 32'h00000007);
		wb(1'b1, ctl_a, 4'hf, 32'hffffffff);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		wb(1'b0, ctl_a, 4'hf, 32'h0);
		chk(q, 32'h00000000);
		$display("test resets done");
		@(posedge clk);
		chan_hit <= 1'b1;
		rx(1'b1, 32'h000000a1, 1'b0, 1'b0);
		wb(1'b1, ctl_a, 4'hf, 32'h00000001);
		rx(1'b1, 32'h000000a2, 1'b1, 1'b1);
		rx(1'b0, 32'h000000a3, 1'b1, 1'b0);
		@(posedge clk);
		chan_hit <= 1'b0;
		rx(1'b0, 32'h000000a4, 1'b0, 1'b0);
		wb(1'b1, ctl_a, 4'hf, 32'h00008001);
		rx(1'b0, 32'h000000a5, 1'b1, 1'b0);
		wb(1'b1, ctl_a, 4'hf, 32'h00080001);
		@(posedge clk);
		chan_hit <= 1'b1;
		rx(1'b1, 32'h5a5a00c3, 1'b0, 1'b0);
		chk(hdr, 32'h5a5a00c3);
		rx(1'b0, 32'h000000a6, 1'b1, 1'b1);
		wb(1'b0, hdr_a, 4'hf, 32'h0);
		chk(q, 32'h5a5a00c3);
		$display("test receive done");
		wb(1'b1, ctl_a, 4'hf, 32'h00000000);
		@(posedge clk);
		head <= '{vld: 1'b1, sop: 1'b0, data: 32'h000000b1};
		rd(1'b1, 1'b0, 1'b1);
		chk(mrd_data, 32'h000000b1);
		rd(1'b0, 1'b1, 1'b0);
		chk({31'h0, bulk_rx.vld}, 32'h0);
		wb(1'b1, ctl_a, 4'hf, 32'h00100000);
		@(posedge clk);
		head <= '{vld: 1'b1, sop: 1'b0, data: 32'h000000b2};
		rd(1'b1, 1'b0, 1'b0);
		chk(mrd_data, 32'h000000b1);
		rd(1'b0, 1'b1, 1'b1);
		chk({31'h0, bulk_rx.vld}, 32'h1);
		chk(bulk_rx.data, 32'h000000b2);
		$display("test fifo read done");
		// source select clear then set, transmit fifo takes micro then bulk port quadlets
		wb(1'b1, ctl_a, 4'hf, 32'h00000000);
		tx(32'h000000c1, 32'h000000c2, 32'h000000c1);
		wb(1'b1, ctl_a, 4'hf, 32'h00200000);
		tx(32'h000000c3, 32'h000000c4, 32'h000000c4);
		$display("test transmit done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
